// *** core/serial_tx_pkg.sv ***
// Purpose: Shared constants and types of the serial transmitter
// Assumes: 8-bit register port, word addresses 0 to 4
// Notes:   Field positions hold for the register port only
package serial_tx_pkg;

  // Register addresses
  localparam logic [2:0] ADDR_DATA    = 3'h0;
  localparam logic [2:0] ADDR_CSA     = 3'h1;
  localparam logic [2:0] ADDR_CSB     = 3'h2;
  localparam logic [2:0] ADDR_SHARED  = 3'h3;
  localparam logic [2:0] ADDR_BAUD_LO = 3'h4;

  // Control and status A fields
  localparam int BIT_DONE_FLAG  = 6;
  localparam int BIT_EMPTY_FLAG = 5;
  localparam int BIT_DBL_SPEED  = 1;
  // Control and status B fields
  localparam int BIT_DONE_IE    = 6;
  localparam int BIT_EMPTY_IE   = 5;
  localparam int BIT_TX_ENABLE  = 3;
  localparam int BIT_SIZE_TOP   = 2;
  localparam int BIT_NINTH      = 0;
  // Frame control fields (shared location)
  localparam int BIT_LOC_SEL    = 7;
  localparam int BIT_SYNC_MODE  = 6;
  localparam int BIT_PAR_HI     = 5;
  localparam int BIT_PAR_LO     = 4;
  localparam int BIT_STOP_SEL   = 3;
  localparam int BIT_SIZE_HI    = 2;
  localparam int BIT_SIZE_LO    = 1;
  localparam int BIT_CLK_POL    = 0;

  // Reset values and codes
  localparam logic [1:0] SIZE_LOW_RESET = 2'h3;
  localparam logic [2:0] SIZE_NINE      = 3'h7;
  localparam logic [4:0] DIV_NORMAL     = 5'h10;
  localparam logic [4:0] DIV_DOUBLE     = 5'h08;
  localparam int         BAUD_W         = 12;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_START  = 3'b001,
    ST_DATA   = 3'b010,
    ST_PARITY = 3'b011,
    ST_STOP1  = 3'b100,
    ST_STOP2  = 3'b101
  } tx_state_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic [7:0]        rdata;
    logic [BAUD_W-1:0] baud_cnt;
    logic [BAUD_W-1:0] baud_div;
    logic [3:0]        div_cnt;
    logic              dbl;
    logic              done_flag;
    logic              done_ie;
    logic              empty_ie;
    logic              ten;
    logic              ninth;
    logic [2:0]        size;
    logic              sync;
    logic              pol;
    logic [1:0]        pmode;
    logic              two_stop;
    logic              buf_full;
    logic [8:0]        buf_data;
    logic [8:0]        shreg;
    logic              par;
    logic [3:0]        bit_cnt;
    tx_state_t         st;
    logic              line;
    logic              override;
    logic              txd;
    logic              xck_q;
    logic              xck_oe;
    logic              xck_prev;
    logic              irq_empty;
    logic              irq_done;
  } core_t;

endpackage

// *** core/serial_tx.sv ***
// Purpose: Transmit half of a serial port with parity and sync clock
// Assumes: One 10 MHz clock, all inputs synchronous to it
// Notes:   Receiver path is absent; its flag reads as zero
//
// Operation
// R1: Even parity bit is the XOR of all sent data bits.
// R2: Odd parity inverts that XOR.
// R3: Parity bit sits after last data bit when parity upper bit set.
// R4: Transmit enable hands the data pin to the transmitter.
// R5: Sync mode with transmitter on takes over the external clock pin.
// R6: Writing the data location fills the buffer and starts sending.
// R7: Buffer moves to shifter when idle or right after last stop bit.
// R8: A frame is sent at baud divisor rate or external clock rate.
// R9: Upper bits beyond character size are ignored.
// R10: Nine-bit size sends the ninth bit; software sets it first.
// R11: Buffer-empty flag clears on write, sets when data moves on.
// R12: Software writes zero to the buffer-empty flag position.
// R13: Buffer-empty interrupt requested while flag set and enabled.
// R14: Complete flag sets when frame is out and buffer is empty.
// R15: Complete flag clears on interrupt service or written one.
// R16: Complete interrupt requested when flag set and enabled.
// R17: Software sets rate and format before use, interrupts off.
// R18: Software changes format only when idle; clears complete first.
// R19: Shared location writes frame control only with top bit set.
// R20: Start bit low, data LSB first, stop bits and idle high.
// R21: Bit clock is baud output divided by 16, 8 or 2.
// R22: Disable waits until shifter and buffer are empty, then releases.
// R23: No parity bit when parity upper bit is zero.
// R24: Two stop bits when stop select set, else one.
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

module serial_tx (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  // Register port
  input  wire serial_tx_pkg::reg_req_t req,
  output logic [7:0]                  rdata,
  // Interrupt handshake
  input  wire logic                   global_irq_enable,
  input  wire logic                   tx_complete_ack,
  output logic                        irq_buffer_empty,
  output logic                        irq_tx_complete,
  // Data pin
  input  wire logic                   port_data,
  output logic                        txd,
  output logic                        txd_overridden,
  // External clock pin
  input  wire logic                   xck_dir_master,
  input  wire logic                   ext_serial_clock_pin_in,
  output logic                        ext_serial_clock_pin_out,
  output logic                        ext_serial_clock_pin_oe
);
  import serial_tx_pkg::*;

  core_t q;
  core_t next_q;
  logic  tick;
  logic  master;
  logic  slave;
  logic  bit_en;
  logic  load;
  logic  frame_end;
  logic  data_wr;
  logic [3:0] nbits;
  logic [8:0] masked;

  // Outputs straight from state flops
  assign rdata                    = q.rdata;
  assign irq_buffer_empty         = q.irq_empty;
  assign irq_tx_complete          = q.irq_done;
  assign txd                      = q.txd;
  assign txd_overridden           = q.override;
  assign ext_serial_clock_pin_out = q.xck_q;
  assign ext_serial_clock_pin_oe  = q.xck_oe;

  // Character width; reserved size codes fall back to eight bits
  always_comb begin
    case (q.size)
      3'h0: nbits = 4'h5;
      3'h1: nbits = 4'h6;
      3'h2: nbits = 4'h7;
      SIZE_NINE: nbits = 4'h9;
      default: nbits = 4'h8;
    endcase
  end

  // R9 drop upper bits
  assign masked = q.buf_data & 9'((10'h001 << nbits) - 10'h001);

  // Next state of the whole block
  always_comb begin
    next_q    = q;
    load      = 1'b0;
    frame_end = 1'b0;
    bit_en    = 1'b0;
    master    = q.sync & xck_dir_master;
    slave     = q.sync & ~xck_dir_master;
    data_wr   = req.wr && req.addr == ADDR_DATA && q.ten;

    // R21 baud down-counter, output each time it reaches zero
    tick = (q.baud_cnt == '0);
    next_q.baud_cnt = tick ? q.baud_div : q.baud_cnt - 1'b1;

    // R8 bit rate by mode; slave follows pin, master halves ticks
    next_q.xck_prev = ext_serial_clock_pin_in;
    if (slave) begin
      bit_en = (ext_serial_clock_pin_in != q.xck_prev) &&
               (ext_serial_clock_pin_in == ~q.pol);
    end else if (master) begin
      if (tick) begin
        next_q.xck_q = ~q.xck_q;
      end
      bit_en = tick && (~q.xck_q == ~q.pol);
    end else if (tick) begin
      next_q.div_cnt = q.div_cnt + 1'b1;
      if ({1'b0, q.div_cnt} == (q.dbl ? DIV_DOUBLE : DIV_NORMAL) - 5'h01)
      begin
        next_q.div_cnt = '0;
        bit_en = 1'b1;
      end
    end

    // R20 frame sequencer: each state is the bit now on the line
    if (bit_en) begin
      case (q.st)
        ST_IDLE: begin
          // R7 load when idle
          load = q.buf_full;
        end
        ST_START: begin
          next_q.line    = q.shreg[0];
          next_q.shreg   = q.shreg >> 1;
          next_q.bit_cnt = 4'h1;
          next_q.st      = ST_DATA;
        end
        ST_DATA: begin
          if (q.bit_cnt == nbits) begin
            // R3 parity after last data bit
            if (q.pmode[1]) begin
              next_q.line = q.par;
              next_q.st   = ST_PARITY;
            end else begin
              // R23 stop follows data directly
              next_q.line = 1'b1;
              next_q.st   = ST_STOP1;
            end
          end else begin
            next_q.line    = q.shreg[0];
            next_q.shreg   = q.shreg >> 1;
            next_q.bit_cnt = q.bit_cnt + 1'b1;
          end
        end
        ST_PARITY: begin
          next_q.line = 1'b1;
          next_q.st   = ST_STOP1;
        end
        ST_STOP1: begin
          // R24 second stop bit on request
          if (q.two_stop) begin
            next_q.st = ST_STOP2;
          end else begin
            frame_end = 1'b1;
          end
        end
        ST_STOP2: begin
          frame_end = 1'b1;
        end
        default: begin
          next_q.st   = ST_IDLE;
          next_q.line = 1'b1;
        end
      endcase
    end

    // R7 reload right after the last stop bit
    if (frame_end) begin
      load = q.buf_full;
      if (!q.buf_full) begin
        next_q.st   = ST_IDLE;
        next_q.line = 1'b1;
      end
    end

    // R10 ninth bit rides in buffer top; R1 R2 parity at load
    if (load) begin
      next_q.shreg    = masked;
      next_q.par      = (^masked) ^ q.pmode[0];
      next_q.buf_full = 1'b0;
      next_q.line     = 1'b0;
      next_q.st       = ST_START;
    end

    // Register writes
    if (req.wr) begin
      case (req.addr)
        ADDR_CSA: begin
          next_q.dbl = req.wdata[BIT_DBL_SPEED];
          // R15 written one clears
          if (req.wdata[BIT_DONE_FLAG]) begin
            next_q.done_flag = 1'b0;
          end
        end
        ADDR_CSB: begin
          next_q.done_ie  = req.wdata[BIT_DONE_IE];
          next_q.empty_ie = req.wdata[BIT_EMPTY_IE];
          next_q.ten      = req.wdata[BIT_TX_ENABLE];
          next_q.size[2]  = req.wdata[BIT_SIZE_TOP];
          next_q.ninth    = req.wdata[BIT_NINTH];
        end
        ADDR_SHARED: begin
          // R19 top bit routes to frame control
          if (req.wdata[BIT_LOC_SEL]) begin
            next_q.sync      = req.wdata[BIT_SYNC_MODE];
            next_q.pmode     = {req.wdata[BIT_PAR_HI],
                                req.wdata[BIT_PAR_LO]};
            next_q.two_stop  = req.wdata[BIT_STOP_SEL];
            next_q.size[1:0] = {req.wdata[BIT_SIZE_HI],
                                req.wdata[BIT_SIZE_LO]};
            next_q.pol       = req.wdata[BIT_CLK_POL];
          end else begin
            next_q.baud_div[11:8] = req.wdata[3:0];
          end
        end
        ADDR_BAUD_LO: begin
          // Reload so a new rate takes hold at once
          next_q.baud_div[7:0] = req.wdata;
          next_q.baud_cnt      = {q.baud_div[11:8], req.wdata};
        end
        default: begin
        end
      endcase
    end

    // R6 R11 data write fills buffer, after a same-cycle load
    if (data_wr) begin
      next_q.buf_data = {q.ninth, req.wdata};
      next_q.buf_full = 1'b1;
    end

    // R15 service clears; R14 set wins over any clear
    if (tx_complete_ack) begin
      next_q.done_flag = 1'b0;
    end
    // A write landing in the same cycle means the buffer is not empty
    if (frame_end && !q.buf_full && !data_wr) begin
      next_q.done_flag = 1'b1;
    end

    // R13 R16 interrupt requests, levels from flag state
    next_q.irq_empty = next_q.empty_ie & global_irq_enable &
                       ~next_q.buf_full;
    next_q.irq_done  = next_q.done_ie & global_irq_enable &
                       next_q.done_flag;

    // R4 R22 pin held while enabled or anything still to send
    next_q.override = next_q.ten | next_q.buf_full |
                      (next_q.st != ST_IDLE);
    next_q.txd = next_q.override ? next_q.line : port_data;
    // R5 master drives the clock pin while transmitter owns it
    next_q.xck_oe = next_q.sync & xck_dir_master & next_q.override;

    // Read data valid only in the cycle after the strobe
    next_q.rdata = 8'h00;
    if (req.rd) begin
      case (req.addr)
        ADDR_CSA: begin
          next_q.rdata[BIT_DONE_FLAG]  = q.done_flag;
          next_q.rdata[BIT_EMPTY_FLAG] = ~q.buf_full;
          next_q.rdata[BIT_DBL_SPEED]  = q.dbl;
        end
        ADDR_CSB: begin
          next_q.rdata[BIT_DONE_IE]   = q.done_ie;
          next_q.rdata[BIT_EMPTY_IE]  = q.empty_ie;
          next_q.rdata[BIT_TX_ENABLE] = q.ten;
          next_q.rdata[BIT_SIZE_TOP]  = q.size[2];
          next_q.rdata[BIT_NINTH]     = q.ninth;
        end
        ADDR_SHARED: begin
          next_q.rdata = {1'b1, q.sync, q.pmode, q.two_stop,
                          q.size[1:0], q.pol};
        end
        ADDR_BAUD_LO: begin
          next_q.rdata = q.baud_div[7:0];
        end
        default: begin
          next_q.rdata = 8'h00;
        end
      endcase
    end
  end

  // State register; line idles high and buffer starts empty
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q           <= '0;
      q.size      <= {1'b0, SIZE_LOW_RESET};
      q.line      <= 1'b1;
      q.st        <= ST_IDLE;
    end else begin
      q <= next_q;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence frame_done_s;
    frame_end && !q.buf_full && !data_wr;
  endsequence

  sequence move_s;
    load && !data_wr;
  endsequence

  even_parity_a: assert property (load && q.pmode == 2'b10 |=> // R1
    q.par == ^$past(masked)) else $error("even parity wrong");
  odd_parity_a: assert property (load && q.pmode == 2'b11 |=> // R2
    q.par == ~^$past(masked)) else $error("odd parity wrong");
  parity_slot_a: assert property (q.st == ST_PARITY |-> // R3
    q.line == q.par && q.pmode[1]) else $error("parity slot bad");
  pin_owned_a: assert property (q.ten |-> // R4
    txd_overridden && txd == q.line) else $error("pin not taken over");
  start_low_a: assert property ($rose(q.st == ST_START) |-> // R20
    !q.line && txd == q.line) else $error("start bit not low");
  stop_high_a: assert property (q.st == ST_STOP1 || // R20
    q.st == ST_STOP2 |-> q.line) else $error("stop bit not high");
  write_fills_a: assert property (data_wr |=> q.buf_full) // R11
    else $error("buffer not filled");
  move_empties_a: assert property (move_s |=> // R7
    !q.buf_full ##0 q.st == ST_START) else $error("load failed");
  done_set_a: assert property (frame_done_s |=> // R14
    q.done_flag && irq_tx_complete == (q.done_ie &&
    $past(global_irq_enable))) else $error("done flag not set");
  empty_irq_a: assert property (irq_buffer_empty == // R13
    (q.empty_ie && $past(global_irq_enable) && !q.buf_full))
    else $error("empty irq wrong");
  release_a: assert property (!q.ten && q.st == ST_IDLE && // R22
    !q.buf_full |-> !txd_overridden)
    else $error("pin not released");

endmodule

// *** verification/serial_line_rx.sv ***
// Purpose: Far-end serial receiver watching the transmit line
// Assumes: Bench gives the bit length in clocks, an even number
// Notes:   Samples on the falling clock edge, away from design updates
`timescale 1ns/1ps

module serial_line_rx (
  // Clock and line
  input  wire logic       clk,
  input  wire logic       line,
  input  wire logic       owned,
  // Frame shape chosen by the bench
  input  wire logic [3:0] nbits,
  input  wire logic       par_en,
  input  wire logic [4:0] bit_clks,
  // Captured frame
  output logic [8:0]      data,
  output logic            par,
  output logic            framing_ok,
  output int              frames
);
  // Hunt for a start edge, then sample every bit in its middle;
  // ignoring the line while not owned avoids port-data false starts
  initial begin
    frames = 0;
    data = '0;
    par = 1'b0;
    framing_ok = 1'b0;
    forever begin
      @(negedge clk);
      if (owned && line === 1'b0) begin
        repeat (bit_clks >> 1) @(negedge clk);
        framing_ok = (line === 1'b0);
        data = '0;
        for (int i = 0; i < nbits; i++) begin
          repeat (bit_clks) @(negedge clk);
          data[i] = line;
        end
        if (par_en) begin
          repeat (bit_clks) @(negedge clk);
          par = line;
        end
        repeat (bit_clks) @(negedge clk);
        framing_ok = framing_ok && (line === 1'b1);
        frames++;
      end
    end
  end
endmodule

// *** verification/testbench.sv ***
// Purpose: Self-checking bench for the serial transmitter
// Assumes: Divisor 0, so a bit lasts 16, 8 or 2 clocks by mode
// Notes:   Register accesses follow the one-cycle strobe protocol
`timescale 1ns/1ps

module testbench;
  import serial_tx_pkg::*;
  logic       clk, sys_rst, global_irq_enable, tx_complete_ack;
  logic       port_data, xck_dir_master, xck_in;
  reg_req_t   req;
  logic [7:0] rdata, rd_val;
  logic       irq_buffer_empty, irq_tx_complete;
  logic       txd, txd_overridden, xck_oe, xck_out, clk_seen;
  logic [3:0] nbits;
  logic [4:0] bit_clks;
  logic       par_en, rx_par, rx_ok;
  logic [8:0] rx_data;
  int         frames, errors, checks_done, n;

  serial_tx u_serial_tx (.clk, .sys_rst, .req, .rdata, .global_irq_enable,
    .tx_complete_ack, .irq_buffer_empty, .irq_tx_complete, .port_data,
    .txd, .txd_overridden, .xck_dir_master,
    .ext_serial_clock_pin_in(xck_in), .ext_serial_clock_pin_out(xck_out),
    .ext_serial_clock_pin_oe(xck_oe));

  serial_line_rx u_serial_line_rx (.clk, .line(txd), .owned(txd_overridden),
    .nbits, .par_en, .bit_clks, .data(rx_data), .par(rx_par),
    .framing_ok(rx_ok), .frames);

  // Clock generator
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [8:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  // Bounded wait for the far end to count frame k
  task automatic wait_frame(input int k);
    repeat (400) begin
      if (frames >= k) break;
      @(posedge clk);
    end
    check("frame count", 9'(frames), 9'(k));
  endtask

  // One frame in a given format; parity and mask worked out here
  task automatic send(input logic [2:0] sz, input logic [1:0] pm,
                      input logic st, dbl, input logic [8:0] d);
    logic [8:0] exp;
    logic [7:0] fc;
    nbits = (sz == SIZE_NINE) ? 4'd9 : 4'(sz) + 4'd5;
    par_en = pm[1];
    bit_clks = dbl ? 5'd8 : 5'd16;
    exp = d & (9'h1FF >> (9 - nbits));
    fc = {2'b10, pm, st, sz[1:0], 1'b0};
    reg_wr(ADDR_SHARED, fc);
    reg_wr(ADDR_SHARED, 8'h00);
    reg_rd(ADDR_SHARED, rd_val);
    check("frame control", 9'(rd_val), 9'(fc));
    reg_wr(ADDR_CSB, {4'h0, 1'b1, sz[2], 1'b0, d[8]});
    reg_wr(ADDR_CSA, {6'h10, dbl, 1'b0});
    n = frames;
    reg_wr(ADDR_DATA, d[7:0]);
    wait_frame(n + 1);
    check("data bits", rx_data, exp);
    if (pm[1]) check("parity", 9'(rx_par), 9'(^exp ^ pm[0]));
    check("start and stop", 9'(rx_ok), 9'h001);
    repeat (12) @(posedge clk);
    reg_rd(ADDR_CSA, rd_val);
    check("complete flag", 9'(rd_val[6]), {8'h00, !st});
    // Let a second stop bit finish before the format is touched again
    repeat (24) @(posedge clk);
  endtask

  // Watchdog: all tests take well under 10000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    test_done();
  end

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    req = '0;
    global_irq_enable = 1'b0;
    tx_complete_ack = 1'b0;
    port_data = 1'b1;
    xck_dir_master = 1'b0;
    xck_in = 1'b0;
    nbits = 4'd8;
    par_en = 1'b0;
    bit_clks = 5'd16;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    reg_rd(ADDR_CSA, rd_val);
    check("status after reset", 9'(rd_val), 9'h020);
    reg_rd(ADDR_SHARED, rd_val);
    check("frame after reset", 9'(rd_val), 9'h086);
    reg_rd(3'h5, rd_val);
    check("unmapped read", 9'(rd_val), 9'h000);
    check("pin before enable", 9'(txd_overridden), 9'h000);
    reg_wr(ADDR_BAUD_LO, 8'h00);
    reg_wr(ADDR_CSB, 8'h08);
    repeat (3) @(posedge clk);
    check("pin owned", 9'(txd_overridden), 9'h001);
    check("idle line", 9'(txd), 9'h001);
    send(3'h0, 2'b10, 1'b0, 1'b0, 9'h0FF);
    send(3'h1, 2'b11, 1'b1, 1'b0, 9'h0C5);
    send(3'h2, 2'b00, 1'b0, 1'b1, 9'h0FE);
    send(3'h3, 2'b10, 1'b1, 1'b0, 9'h03C);
    send(3'h7, 2'b11, 1'b0, 1'b0, 9'h1A5);
    // Two characters back to back; the second waits in the buffer
    par_en = 1'b0;
    nbits = 4'd8;
    reg_wr(ADDR_SHARED, 8'h86);
    reg_wr(ADDR_CSB, 8'h08);
    reg_wr(ADDR_CSA, 8'h40);
    n = frames;
    reg_wr(ADDR_DATA, 8'h12);
    repeat (40) begin
      if (txd === 1'b0) break;
      @(posedge clk);
    end
    check("start seen", 9'(txd), 9'h000);
    reg_wr(ADDR_DATA, 8'h34);
    reg_rd(ADDR_CSA, rd_val);
    check("buffer held", 9'(rd_val), 9'h000);
    wait_frame(n + 1);
    check("first char", rx_data, 9'h012);
    repeat (10) @(posedge clk);
    check("next start", 9'(txd), 9'h000);
    wait_frame(n + 2);
    check("second char", rx_data, 9'h034);
    repeat (12) @(posedge clk);
    reg_rd(ADDR_CSA, rd_val);
    check("both done", 9'(rd_val), 9'h060);
    // Interrupt requests and service
    @(posedge clk);
    global_irq_enable <= 1'b1;
    reg_wr(ADDR_CSB, 8'h68);
    repeat (3) @(posedge clk);
    check("empty request", 9'(irq_buffer_empty), 9'h001);
    check("done request", 9'(irq_tx_complete), 9'h001);
    tx_complete_ack <= 1'b1;
    @(posedge clk);
    tx_complete_ack <= 1'b0;
    repeat (3) @(posedge clk);
    check("done serviced", 9'(irq_tx_complete), 9'h000);
    global_irq_enable <= 1'b0;
    repeat (3) @(posedge clk);
    check("empty masked", 9'(irq_buffer_empty), 9'h000);
    // Disable with a character still waiting in the buffer waits for its frame to finish
    port_data <= 1'b0;
    n = frames;
    reg_wr(ADDR_DATA, 8'h5A);
    reg_wr(ADDR_CSB, 8'h00);
    repeat (3) @(posedge clk);
    check("held while busy", 9'(txd_overridden), 9'h001);
    wait_frame(n + 1);
    check("last char", rx_data, 9'h05A);
    repeat (30) @(posedge clk);
    check("pin released", 9'(txd_overridden), 9'h000);
    check("port data back", 9'(txd), 9'h000);
    // Sync master takes the clock pin
    xck_dir_master <= 1'b1;
    reg_wr(ADDR_SHARED, 8'hC6);
    reg_wr(ADDR_CSB, 8'h08);
    repeat (3) @(posedge clk);
    check("clock pin driven", 9'(xck_oe), 9'h001);
    // Master clock flips on every baud tick with divisor 0
    @(negedge clk);
    clk_seen = xck_out;
    @(negedge clk);
    check("clock toggles", 9'(xck_out ^ clk_seen), 9'h001);
    bit_clks = 5'd2;
    n = frames;
    reg_wr(ADDR_DATA, 8'h96);
    wait_frame(n + 1);
    check("sync char", rx_data, 9'h096);
    check("sync framing", 9'(rx_ok), 9'h001);
    test_done();
  end
endmodule
